// ==== inc/lts_defs.svh ====
`ifndef LTS_DEFS_SVH
`define LTS_DEFS_SVH
// register map of the plain command port
`define LTS_ADDR_CTRL    4'h0
`define LTS_ADDR_SRC     4'h1
`define LTS_ADDR_CNT1    4'h2
`define LTS_ADDR_CNT2    4'h3
`define LTS_ADDR_CNTT    4'h4
`define LTS_ADDR_TIMER   4'h5
`define LTS_ADDR_DLY2    4'h6
`define LTS_ADDR_DLYT    4'h7
`define LTS_ADDR_CMD     4'h8
`define LTS_ADDR_STAT    4'h9
`define LTS_ADDR_LINE    4'hA
// source codes
`define LTS_SRC_NOWAIT   3'h0
`define LTS_SRC_KEY      3'h1
`define LTS_SRC_BUS      3'h2
`define LTS_SRC_TIMER    3'h3
`define LTS_SRC_EXT      3'h4
`define LTS_SRC_TRIGGER_BUS_SOURCE    3'h5
`define LTS_SRC_TOD      3'h6
`define LTS_SRC_STALL    3'h7
// command bits
`define LTS_CMD_INIT     0
`define LTS_CMD_RESET    1
`define LTS_CMD_IMM1     2
`define LTS_CMD_IMM2     3
`define LTS_CMD_IMMT     4
`define LTS_CMD_BUSTRG   5
// control bits
`define LTS_CTRL_CONT    0
`define LTS_CTRL_BYP1    1
`define LTS_CTRL_BYP2    2
`define LTS_CTRL_BYPT    3
`define LTS_CTRL_SCAN    4
`define LTS_CTRL_INTCH   5
`define LTS_CTRL_SEMI    6
// ticks and pulses
`define LTS_CLK_HZ       20000000
`define LTS_MS_CYCLES    (`LTS_CLK_HZ / 1000)
`define LTS_PULSE_CYC    8'h14
`define LTS_SETTLE_CYC   16'h2710
`define LTS_ZERO32       32'h0000_0000
`endif

// ==== inc/lts_pkg.sv ====
package lts_pkg;
  typedef enum logic [7:0] {
    LTS_IDLE  = 8'h01,
    LTS_ARM1  = 8'h02,
    LTS_ARM2  = 8'h04,
    LTS_DLY2  = 8'h08,
    LTS_TRIG  = 8'h10,
    LTS_DLYT  = 8'h20,
    LTS_OPEN  = 8'h40,
    LTS_MEAS  = 8'h80
  } lts_state_t;
endpackage

// ==== hw/lts_sequencer.sv ====
// Notes on behaviour
// [RULE_01] idle does nothing; leaves only on initiate or continuous mode
// [RULE_02] continuous mode re-initiates; reset command forces idle at any time
// [RULE_03] descend arm1, arm2, trigger layer, then device action
// [RULE_04] each layer waits for its source; no-wait passes at once
// [RULE_05] front-key source uses key press, ignored while remote
// [RULE_06] bus source satisfied only by host bus trigger
// [RULE_07] timer passes first time, then per interval; reset on climb; not arm1
// [RULE_08] rear input and trigger-bus sources use their input triggers
// [RULE_09] time-of-day source only in arm1
// [RULE_10] stall source never satisfied; only immediate command passes
// [RULE_11] bypass skips ext or trigger-bus source on first pass only
// [RULE_12] arm layer output trigger only with that layer's bypass enabled
// [RULE_13] immediate command skips source; arm1 and trigger also skip delay
// [RULE_14] arm2 and trigger layer apply programmable delay after detection
// [RULE_15] scan closes channel before measuring; internal opens first and settles
// [RULE_16] arm output goes to trigger bus if selected, else measure done
// [RULE_17] trigger layer outputs after every device action
// [RULE_18] trigger-bus async pulses; semi-sync releases or pulls low then releases
// [RULE_19] per-layer loop counters, zero means infinite, reset on climb
// [RULE_20] arm1 exhausted without continuous returns idle, clears armed
`timescale 1ns/100ps
`default_nettype none
`include "lts_defs.svh"
module lts_sequencer
  import lts_pkg::*;
#(
  parameter int TICK_CYC = `LTS_MS_CYCLES
)(
  input  wire logic        clock,        // system clock
  input  wire logic        rst,          // sync reset
  input  wire logic [3:0]  regAddr,      // register address
  input  wire logic [31:0] regWdata,     // write data
  input  wire logic        regWr,        // write strobe
  input  wire logic        regRd,        // read strobe
  output logic      [31:0] regRdata,     // read data
  input  wire logic        extTrigIn,    // rear trigger pin
  input  wire logic        linkTrigIn,   // trigger bus input pin
  input  wire logic        keyPress,     // front trigger key pin
  input  wire logic        remoteMode,   // remote operation level
  input  wire logic        todMatch,     // time of day reached
  input  wire logic        measDone,     // measurement finished
  output logic             measStart,    // start measurement pulse
  output logic             chanClose,    // close channel pulse
  output logic             chanOpen,     // open previous channel pulse
  output logic             armedInd,     // armed indication
  output logic             measureDoneOutput, // measure done output pulse
  output logic             linkOut,      // trigger bus line out (low)
  output logic             linkOe        // trigger bus drive enable
);
  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    lts_state_t  st;
    logic [6:0]  ctrl;
    logic [8:0]  src;          // arm1, arm2, trig sources
    logic [31:0] cnt1, cnt2, cntT, lim1, lim2, limT;
    logic [31:0] tmrMs, dly2Ms, dlyTMs, tmrRun, dlyRun;
    logic [31:0] tick;
    logic [15:0] settle;
    logic [7:0]  pulse;
    logic        pulseLink;
    logic [2:0]  first;        // first pass flags per layer
    logic        tmrFirst;
    logic        busTrg;
    logic [2:0]  imm;
    logic        measReq;
    logic [2:0]  ext3, link3, key3;
    logic        holdLow;
    logic [31:0] rdata;
    logic        mStart, cClose, cOpen;
  } lts_reg_t;
  lts_reg_t s_r, s_nxt;

  // ****************************************
  // synchronised pin events
  // ****************************************
  logic extEv, linkEv, keyEv, tmrDone;
  // rear and bus trigger inputs count once stages 2 and 3 agree high
  assign extEv  = s_r.ext3[1] & s_r.ext3[2];                         // [RULE_08]
  assign linkEv = s_r.link3[1] & s_r.link3[2];                       // [RULE_08]
  // key is edge detected so a held key fires once; locked out in remote
  assign keyEv  = s_r.key3[1] & s_r.key3[2] & ~s_r.holdLow & ~remoteMode;  // [RULE_05]
  // interval satisfied on the first pass or once the countdown ran out
  assign tmrDone = s_r.tmrFirst | (s_r.tmrRun == `LTS_ZERO32);       // [RULE_07]
  // ****************************************
  // next state
  // ****************************************
  function automatic logic srcHit(input logic [2:0] code, input logic tmrOk, input logic todOk,
                                  input logic e, input logic l, input logic k, input logic b);
    logic h;
    h = 1'b0;
    unique case (code)
      `LTS_SRC_NOWAIT: h = 1'b1;                    // [RULE_04]
      `LTS_SRC_KEY:    h = k;                       // [RULE_05]
      `LTS_SRC_BUS:    h = b;                       // [RULE_06]
      `LTS_SRC_TIMER:  h = tmrOk;                   // [RULE_07]
      `LTS_SRC_EXT:    h = e;                       // [RULE_08]
      `LTS_SRC_TRIGGER_BUS_SOURCE:  h = l;                       // [RULE_08]
      `LTS_SRC_TOD:    h = todOk;                   // [RULE_09]
      `LTS_SRC_STALL:  h = 1'b0;                    // [RULE_10]
    endcase
    return h;
  endfunction

  always_comb
  begin
    logic [2:0] sc;
    logic       hit;
    logic       byp;
    logic       skip;
    logic       isTick;
    s_nxt  = s_r;
    sc     = 3'h0;
    hit    = 1'b0;
    byp    = 1'b0;
    skip   = 1'b0;
    isTick = 1'b0;
    // three-stage pin sync; change counts when stages 2 and 3 agree
    s_nxt.ext3  = {s_r.ext3[1:0], extTrigIn};
    s_nxt.link3 = {s_r.link3[1:0], linkTrigIn};
    s_nxt.key3  = {s_r.key3[1:0], keyPress};
    // previous key stage, for the key edge detect
    s_nxt.holdLow = s_r.key3[2];
    // action strobes are single-cycle pulses
    s_nxt.mStart = 1'b0;
    s_nxt.cClose = 1'b0;
    s_nxt.cOpen  = 1'b0;
    // millisecond tick
    isTick = (s_r.tick == 32'(TICK_CYC - 1));
    s_nxt.tick = isTick ? `LTS_ZERO32 : s_r.tick + 32'h1;
    if (isTick && s_r.tmrRun != `LTS_ZERO32) s_nxt.tmrRun = s_r.tmrRun - 32'h1;
    if (isTick && s_r.dlyRun != `LTS_ZERO32) s_nxt.dlyRun = s_r.dlyRun - 32'h1;
    if (s_r.pulse != 8'h00) s_nxt.pulse = s_r.pulse - 8'h01;
    // register writes
    s_nxt.rdata = `LTS_ZERO32;
    if (regWr)
    begin
      unique case (regAddr)
        `LTS_ADDR_CTRL:  s_nxt.ctrl   = regWdata[6:0];
        `LTS_ADDR_SRC:   s_nxt.src    = regWdata[8:0];
        `LTS_ADDR_CNT1:  s_nxt.lim1   = regWdata;
        `LTS_ADDR_CNT2:  s_nxt.lim2   = regWdata;
        `LTS_ADDR_CNTT:  s_nxt.limT   = regWdata;
        `LTS_ADDR_TIMER: s_nxt.tmrMs  = regWdata;
        `LTS_ADDR_DLY2:  s_nxt.dly2Ms = regWdata;
        `LTS_ADDR_DLYT:  s_nxt.dlyTMs = regWdata;
        `LTS_ADDR_CMD:
        begin
          // initiate only counts while idle, so no stale request outlives a run
          if (regWdata[`LTS_CMD_INIT] && s_r.st == LTS_IDLE) s_nxt.measReq = 1'b1;  // [RULE_01]
        end
        default: ;
      endcase
    end
    if (regRd)
    begin
      unique case (regAddr)
        `LTS_ADDR_CTRL:  s_nxt.rdata = {25'h0, s_r.ctrl};
        `LTS_ADDR_SRC:   s_nxt.rdata = {23'h0, s_r.src};
        `LTS_ADDR_CNT1:  s_nxt.rdata = s_r.lim1;
        `LTS_ADDR_CNT2:  s_nxt.rdata = s_r.lim2;
        `LTS_ADDR_CNTT:  s_nxt.rdata = s_r.limT;
        `LTS_ADDR_TIMER: s_nxt.rdata = s_r.tmrMs;
        `LTS_ADDR_DLY2:  s_nxt.rdata = s_r.dly2Ms;
        `LTS_ADDR_DLYT:  s_nxt.rdata = s_r.dlyTMs;
        `LTS_ADDR_STAT:  s_nxt.rdata = {24'h0, s_r.st};
        `LTS_ADDR_LINE:  s_nxt.rdata = s_r.cntT;
        default:         s_nxt.rdata = `LTS_ZERO32;
      endcase
    end
    // sequencer
    unique case (s_r.st)
      LTS_IDLE:
      begin
        s_nxt.first = 3'b111;                                   // [RULE_11]
        s_nxt.cnt1 = `LTS_ZERO32;                               // [RULE_19]
        // host triggers mean nothing while idle
        s_nxt.imm = 3'b000;
        s_nxt.busTrg = 1'b0;
        if (s_r.measReq || s_r.ctrl[`LTS_CTRL_CONT])            // [RULE_01]
        begin
          s_nxt.measReq = 1'b0;
          s_nxt.st = LTS_ARM1;
        end
      end
      LTS_ARM1:
      begin
        sc = s_r.src[2:0];
        if (sc == `LTS_SRC_TIMER) sc = `LTS_SRC_STALL;          // [RULE_07]
        byp = s_r.ctrl[`LTS_CTRL_BYP1] & s_r.first[0] &
              (sc == `LTS_SRC_EXT || sc == `LTS_SRC_TRIGGER_BUS_SOURCE);     // [RULE_11]
        hit = srcHit(sc, 1'b0, todMatch, extEv, linkEv, keyEv, s_r.busTrg);
        skip = s_r.imm[0];                                      // [RULE_13]
        if (hit || byp || skip)
        begin
          s_nxt.first[0] = 1'b0;
          s_nxt.imm[0] = 1'b0;
          s_nxt.busTrg = 1'b0;
          s_nxt.first[2:1] = 2'b11;
          s_nxt.cnt2 = `LTS_ZERO32;
          s_nxt.tmrFirst = 1'b1;
          if (s_r.ctrl[`LTS_CTRL_BYP1])                         // [RULE_12]
          begin
            s_nxt.pulse = `LTS_PULSE_CYC;
            s_nxt.pulseLink = (sc == `LTS_SRC_TRIGGER_BUS_SOURCE);           // [RULE_16]
          end
          s_nxt.st = LTS_ARM2;                                  // [RULE_03]
        end
      end
      LTS_ARM2:
      begin
        sc = s_r.src[5:3];
        if (sc == `LTS_SRC_TOD) sc = `LTS_SRC_STALL;            // [RULE_09]
        byp = s_r.ctrl[`LTS_CTRL_BYP2] & s_r.first[1] & (sc == `LTS_SRC_EXT || sc == `LTS_SRC_TRIGGER_BUS_SOURCE);
        hit = srcHit(sc, tmrDone, 1'b0, extEv, linkEv, keyEv, s_r.busTrg);
        if (hit || byp || s_r.imm[1])                           // [RULE_13]
        begin
          s_nxt.first[1] = 1'b0;
          s_nxt.busTrg = 1'b0;
          s_nxt.tmrFirst = 1'b0;
          s_nxt.tmrRun = s_r.tmrMs;
          s_nxt.first[2] = 1'b1;
          s_nxt.cntT = `LTS_ZERO32;
          if (s_r.ctrl[`LTS_CTRL_BYP2])                         // [RULE_12]
          begin
            s_nxt.pulse = `LTS_PULSE_CYC;
            s_nxt.pulseLink = (sc == `LTS_SRC_TRIGGER_BUS_SOURCE);           // [RULE_16]
          end
          s_nxt.dlyRun = s_r.dly2Ms;                            // [RULE_14]
          s_nxt.st = LTS_DLY2;
          s_nxt.imm[1] = 1'b0;
        end
      end
      LTS_DLY2:
        if (s_r.dlyRun == `LTS_ZERO32)
        begin
          s_nxt.tmrFirst = 1'b1;
          s_nxt.st = LTS_TRIG;
        end
      LTS_TRIG:
      begin
        sc = s_r.src[8:6];
        if (sc == `LTS_SRC_TOD) sc = `LTS_SRC_STALL;
        byp = s_r.ctrl[`LTS_CTRL_BYPT] & s_r.first[2] & (sc == `LTS_SRC_EXT || sc == `LTS_SRC_TRIGGER_BUS_SOURCE);
        hit = srcHit(sc, tmrDone, 1'b0, extEv, linkEv, keyEv, s_r.busTrg);
        if (s_r.imm[2])                                         // [RULE_13]
        begin
          s_nxt.imm[2] = 1'b0;
          s_nxt.dlyRun = `LTS_ZERO32;
          s_nxt.st = LTS_DLYT;
        end
        else if (hit || byp)
        begin
          s_nxt.dlyRun = s_r.dlyTMs;                            // [RULE_14]
          s_nxt.st = LTS_DLYT;
        end
        if (hit || byp || s_r.imm[2])
        begin
          s_nxt.first[2] = 1'b0;
          s_nxt.busTrg = 1'b0;
          s_nxt.tmrFirst = 1'b0;
          s_nxt.tmrRun = s_r.tmrMs;
        end
      end
      LTS_DLYT:
        if (s_r.dlyRun == `LTS_ZERO32)
        begin
          if (s_r.ctrl[`LTS_CTRL_SCAN])
          begin
            // internal channels break before make: open now, close next cycle
            s_nxt.cOpen = s_r.ctrl[`LTS_CTRL_INTCH];            // [RULE_15]
            s_nxt.settle = `LTS_SETTLE_CYC;
            s_nxt.st = LTS_OPEN;
          end
          else
          begin
            // no scanner: measure straight away
            s_nxt.mStart = 1'b1;
            s_nxt.st = LTS_MEAS;
          end
        end
      // channel close, then relay settling, then measurement start
      LTS_OPEN:
      begin
        s_nxt.cClose = (s_r.settle == `LTS_SETTLE_CYC);         // [RULE_15]
        if (s_r.settle != 16'h0000) s_nxt.settle = s_r.settle - 16'h0001;
        // zero only guards against a stuck count
        if (s_r.settle == 16'h0001 || s_r.settle == 16'h0000)
        begin
          s_nxt.mStart = 1'b1;                                  // [RULE_15]
          s_nxt.st = LTS_MEAS;
        end
      end
      LTS_MEAS:
        if (measDone)
        begin
          sc = s_r.src[8:6];
          // semi-sync without bypass only releases the bus line: no pulse
          if (!(sc == `LTS_SRC_TRIGGER_BUS_SOURCE && s_r.ctrl[`LTS_CTRL_SEMI] && !s_r.ctrl[`LTS_CTRL_BYPT]))  // [RULE_18]
          begin
            s_nxt.pulse = `LTS_PULSE_CYC;                       // [RULE_17]
            s_nxt.pulseLink = (sc == `LTS_SRC_TRIGGER_BUS_SOURCE);           // [RULE_18]
          end
          s_nxt.cntT = s_r.cntT + 32'h1;
          if (s_r.limT == `LTS_ZERO32 || s_r.cntT + 32'h1 < s_r.limT)   // [RULE_19]
            s_nxt.st = LTS_TRIG;
          else if (s_r.lim2 == `LTS_ZERO32 || s_r.cnt2 + 32'h1 < s_r.lim2)
          begin
            s_nxt.cnt2 = s_r.cnt2 + 32'h1;
            s_nxt.first[2] = 1'b1;
            s_nxt.st = LTS_ARM2;
          end
          else if (s_r.lim1 == `LTS_ZERO32 || s_r.cnt1 + 32'h1 < s_r.lim1)
          begin
            s_nxt.cnt1 = s_r.cnt1 + 32'h1;
            s_nxt.first[2:1] = 2'b11;
            s_nxt.st = LTS_ARM1;
          end
          else
            s_nxt.st = LTS_IDLE;                                // [RULE_20] [RULE_02]
        end
    endcase
    // ****************************************
    // host commands
    // ****************************************
    // triggers latch after the layer logic, so a set beats a same-cycle clear
    if (regWr && regAddr == `LTS_ADDR_CMD && s_r.st != LTS_IDLE)
    begin
      if (regWdata[`LTS_CMD_BUSTRG]) s_nxt.busTrg = 1'b1;      // [RULE_06]
      s_nxt.imm = s_nxt.imm | regWdata[`LTS_CMD_IMMT:`LTS_CMD_IMM1];  // [RULE_13]
    end
    // reset command wins over everything
    if (regWr && regAddr == `LTS_ADDR_CMD && regWdata[`LTS_CMD_RESET])  // [RULE_02]
    begin
      s_nxt.st = LTS_IDLE;
      s_nxt.measReq = 1'b0;
      s_nxt.imm = 3'b000;
      s_nxt.busTrg = 1'b0;
      s_nxt.ctrl[`LTS_CTRL_CONT] = 1'b0;
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      s_r <= '0;
      s_r.st <= LTS_IDLE;
      s_r.first <= 3'b111;
      s_r.tmrFirst <= 1'b1;
    end
    else
      s_r <= s_nxt;
  end

  // outputs
  assign regRdata  = s_r.rdata;
  assign measStart = s_r.mStart;
  assign chanClose = s_r.cClose;
  assign chanOpen  = s_r.cOpen;
  assign armedInd  = (s_r.st != LTS_IDLE);                    // [RULE_20]
  assign measureDoneOutput = (s_r.pulse != 8'h00) & ~s_r.pulseLink;   // [RULE_16]
  // trigger bus: pulse low in async and in semi-sync with bypass; semi-sync without bypass never drives the line
  assign linkOut = 1'b0;
  // semi-sync release is handled where the pulse is started
  assign linkOe  = s_r.pulseLink & (s_r.pulse != 8'h00);    // [RULE_16] [RULE_18]
endmodule // lts_sequencer
`default_nettype wire

// ==== test/lts_sequencer_checker.sv ====
`timescale 1ns/100ps
`default_nettype none
module lts_sequencer_checker (
  input wire logic        clock,             // system clock
  input wire logic        rst,               // sync reset
  input wire logic [3:0]  regAddr,           // register address
  input wire logic [31:0] regWdata,          // write data
  input wire logic        regWr,             // write strobe
  input wire logic        regRd,             // read strobe
  input wire logic [31:0] regRdata,          // read data
  input wire logic        measStart,         // start pulse
  input wire logic        chanClose,         // close pulse
  input wire logic        armedInd,          // armed level
  input wire logic        measureDoneOutput, // done pulse
  input wire logic        linkOut,           // bus line value
  input wire logic        linkOe             // bus line drive
);
  // ************************
  // helper and assertions
  // ************************
  logic [4:0] hiCnt_r;
  // counts consecutive high cycles of the done pulse
  always_ff @(posedge clock)
    hiCnt_r <= (rst || !measureDoneOutput) ? 5'h00 : hiCnt_r + 5'h01;
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  a_done_width: assert property ($fell(measureDoneOutput) |-> hiCnt_r == 5'h14)
    else $error("done pulse not 20 cycles");
  a_done_max: assert property (hiCnt_r <= 5'h14)
    else $error("done pulse too long");
  a_read_quiet: assert property (!$past(regRd) |-> regRdata == 32'h0)
    else $error("read data outside read cycle");
  a_idle_quiet: assert property (!armedInd && !$past(armedInd) |-> !measStart && !chanClose)
    else $error("action while idle");
  a_init_arms: assert property (regWr && regAddr == 4'h8 && regWdata[1:0] == 2'b01 |-> ##2 armedInd)
    else $error("initiate did not arm");
  a_reset_idle: assert property (regWr && regAddr == 4'h8 && regWdata[1] |=> !armedInd [*2])
    else $error("reset command did not idle");
  a_meas_armed: assert property (measStart |-> armedInd && !$past(measStart))
    else $error("bad measure start");
  a_stat_onehot: assert property (regRd && regAddr == 4'h9 |=> $onehot(regRdata[7:0]))
    else $error("state not one-hot");
  a_link_drive: assert property (linkOe |-> !linkOut)
    else $error("bus line driven high");
  a_close_single: assert property (chanClose |=> !chanClose)
    else $error("close pulse too long");
  c_meas: cover property (measStart);
  c_done: cover property ($rose(measureDoneOutput));
  c_link: cover property ($rose(linkOe));
  c_close: cover property (chanClose);
endmodule // lts_sequencer_checker
bind lts_sequencer lts_sequencer_checker u_lts_sequencer_checker (.clock(clock), .rst(rst), .regAddr(regAddr),
  .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .measStart(measStart),
  .chanClose(chanClose), .armedInd(armedInd), .measureDoneOutput(measureDoneOutput), .linkOut(linkOut),
  .linkOe(linkOe));
`default_nettype wire

// ==== test/lts_meter_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module lts_meter_model (
  input wire logic clock,     // system clock
  input wire logic rst,       // sync reset
  input wire logic measStart, // start request
  input wire logic slow,      // long conversion
  output var logic measDone   // finished pulse
);
  logic [5:0] wait_r;
  logic       busy_r;
  // answers each start after a short or long conversion
  always_ff @(posedge clock)
  begin
    measDone <= 1'b0;
    if (rst)
    begin
      busy_r <= 1'b0;
      wait_r <= 6'h00;
    end
    else if (measStart)
    begin
      busy_r <= 1'b1;
      wait_r <= slow ? 6'h28 : 6'h01;
    end
    else if (busy_r && wait_r == 6'h00)
    begin
      busy_r   <= 1'b0;
      measDone <= 1'b1;
    end
    else if (busy_r)
      wait_r <= wait_r - 6'h01;
  end
endmodule // lts_meter_model
`default_nettype wire

// ==== test/test_layered_trigger_sequencer.sv ====
`timescale 1ns/100ps
`default_nettype none
module test_layered_trigger_sequencer;
  import lts_pkg::*;
  logic        clock, rst, regWr, regRd, remoteMode, slow, tod;
  logic [3:0]  regAddr;
  logic [31:0] regWdata, regRdata, v;
  logic [2:0]  trg;
  logic [11:0] seq;
  logic        measStart, chanClose, chanOpen, armedInd, measureDoneOutput, linkOut, linkOe, measDone;
  int          miscompares, tests_run, mc, dc, lc, d, l;
  lts_sequencer #(.TICK_CYC(2)) u_lts_sequencer (.clock(clock), .rst(rst), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .extTrigIn(trg[0]),
    .linkTrigIn(trg[1]), .keyPress(trg[2]), .remoteMode(remoteMode), .todMatch(tod), .measDone(measDone),
    .measStart(measStart), .chanClose(chanClose), .chanOpen(chanOpen), .armedInd(armedInd),
    .measureDoneOutput(measureDoneOutput), .linkOut(linkOut), .linkOe(linkOe));
  lts_meter_model u_lts_meter_model (.clock(clock), .rst(rst), .measStart(measStart), .slow(slow),
    .measDone(measDone));
  // ************************
  // clock, counters, tasks
  // ************************
  always #25 clock = ~clock;
  always @(posedge measStart) mc++;
  always @(posedge measureDoneOutput) dc++;
  always @(posedge linkOe) lc++;
  always @(posedge chanOpen) seq = {seq[7:0], 4'h1};
  always @(posedge chanClose) seq = {seq[7:0], 4'h2};
  always @(posedge measStart) seq = {seq[7:0], 4'h3};
  task results;
    $display("tests %0d miscompares %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e)
    begin
      miscompares++;
      $display("FAIL %0t got %h expected %h", $time, g, e);
    end
  endtask
  task wr(input logic [3:0] a, input logic [31:0] x);
    @(posedge clock);
    regAddr  <= a;
    regWdata <= x;
    regWr    <= 1'b1;
    @(posedge clock);
    regWr <= 1'b0;
  endtask
  task rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge clock);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge clock);
    regRd <= 1'b0;
    #1 chk(regRdata, e);
  endtask
  // programs sources, control and trigger count, then initiates
  task setup(input logic [31:0] s, input logic [31:0] c, input logic [31:0] t);
    wr(4'h1, s);
    wr(4'h0, c);
    wr(4'h4, t);
    wr(4'h8, 32'h1);
  endtask
  task wm(input int k);
    int b;
    b = mc + k;
    for (int i = 0; i < 15000 && mc < b; i++) @(negedge clock);
    chk(mc, b);
  endtask
  task idle;
    for (int i = 0; i < 3000 && armedInd !== 1'b0; i++) @(negedge clock);
    chk({31'h0, armedInd}, 32'h0);
    repeat (30) @(posedge clock);
  endtask
  task pulse(input int b);
    @(posedge clock);
    trg[b] <= 1'b1;
    repeat (5) @(posedge clock);
    trg[b] <= 1'b0;
  endtask
  // ************************
  // watchdog and sequence
  // ************************
  initial
  begin
    repeat (60000) @(posedge clock);
    miscompares++;
    results;
  end
  initial
  begin
    {clock, regWr, regRd, remoteMode, tod, regAddr, regWdata, trg, seq} = '0;
    rst  = 1'b1;
    slow = 1'b1;
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    rd(4'h9, {24'h0, LTS_IDLE});
    rd(4'hF, 32'h0);
    wr(4'h2, 32'h1);
    wr(4'h3, 32'h1);
    wr(4'h5, 32'h1);
    d = dc;
    setup(32'h0, 32'h0, 32'h1);
    wm(1);
    rd(4'h9, {24'h0, LTS_MEAS});
    idle;
    chk(dc - d, 1);
    d = dc;
    setup(32'h0, 32'h2, 32'h1);
    wm(1);
    idle;
    chk(dc - d, 2);
    d = mc;
    setup(32'h1C0, 32'h0, 32'h1);
    repeat (40) @(posedge clock);
    rd(4'h9, {24'h0, LTS_TRIG});
    chk(mc, d);
    wr(4'h8, 32'h10);
    wm(1);
    idle;
    setup(32'h1C0, 32'h0, 32'h1);
    wr(4'h8, 32'h2);
    rd(4'h9, {24'h0, LTS_IDLE});
    setup(32'h10, 32'h0, 32'h1);
    repeat (20) @(posedge clock);
    rd(4'h9, {24'h0, LTS_ARM2});
    wr(4'h8, 32'h20);
    wm(1);
    idle;
    remoteMode <= 1'b1;
    setup(32'h1, 32'h0, 32'h1);
    pulse(2);
    repeat (10) @(posedge clock);
    rd(4'h9, {24'h0, LTS_ARM1});
    remoteMode <= 1'b0;
    pulse(2);
    wm(1);
    idle;
    // time-of-day source holds arm1 until the match level rises
    setup(32'h6, 32'h0, 32'h1);
    repeat (20) @(posedge clock);
    rd(4'h9, {24'h0, LTS_ARM1});
    tod <= 1'b1;
    wm(1);
    @(posedge clock);
    tod <= 1'b0;
    idle;
    setup(32'h100, 32'h8, 32'h2);
    wm(1);
    repeat (60) @(posedge clock);
    rd(4'h9, {24'h0, LTS_TRIG});
    pulse(0);
    wm(1);
    idle;
    wr(4'h3, 32'h2);
    setup(32'h18, 32'h0, 32'h1);
    wm(2);
    idle;
    wr(4'h3, 32'h1);
    {d, l} = {dc, lc};
    setup(32'h140, 32'h0, 32'h1);
    pulse(1);
    wm(1);
    idle;
    chk(lc - l, 1);
    chk(dc - d, 0);
    slow <= 1'b0;
    setup(32'h0, 32'h30, 32'h1);
    wm(1);
    chk(seq, 12'h123);
    idle;
    // slow meter keeps back-to-back done pulses apart in continuous mode
    slow <= 1'b1;
    setup(32'h0, 32'h1, 32'h1);
    wm(1);
    wm(1);
    wr(4'h8, 32'h2);
    rd(4'h9, {24'h0, LTS_IDLE});
    results;
  end
endmodule // test_layered_trigger_sequencer
`default_nettype wire
